// ===== common/sfr_pkg.sv
// Shared types, register map tables and reset values for the register map block.
// Assumes a single core clock domain and one CPU master issuing one request per cycle.
package sfr_pkg;

    // ==============================
    // Request and answer carriers
    // ==============================
    typedef enum logic [2:0] {
        SFR_OP_IDLE = 3'b000,
        SFR_OP_RD = 3'b001,
        SFR_OP_WR = 3'b010,
        SFR_OP_BIT_RD = 3'b011,
        SFR_OP_BIT_SET = 3'b100,
        SFR_OP_BIT_CLR = 3'b101
    } sfr_op_e;

    typedef struct packed {
        sfr_op_e op;
        logic [7:0] addr;
        logic [7:0] wdata;
    } sfr_req_s;

    typedef struct packed {
        logic ack;
        logic hit;
        logic [7:0] rdata;
        logic bit_rdata;
    } sfr_rsp_s;

    typedef struct packed {
        logic valid;
        logic [15:0] addr;
    } sfr_xreq_s;

    // ==============================
    // Register table
    // ==============================
    localparam int NREG = 40;
    localparam int NPTR = 8;
    localparam int IDX_SYS_CTRL = 19;
    localparam int IDX_ANA_SEL = 11;
    localparam int IDX_PTR_SEL = 39;

    // Version register contents; values are arbitrary
    localparam logic [7:0] VERSION_A = 8'h11;
    localparam logic [7:0] VERSION_B = 8'h22;
    localparam logic [7:0] VERSION_C = 8'h33;

    localparam logic [7:0] ADDR_DPL = 8'h82;
    localparam logic [7:0] ADDR_DPH = 8'h83;
    localparam logic [7:0] BIT_AREA_BASE = 8'h80;
    localparam logic [7:0] UNMAPPED_RDATA = 8'h00;
    localparam logic [7:0] CAN_PAGE = 8'hf7;

    // System control field positions
    localparam int SYS_CAN_OFF_BIT = 2;
    localparam int SYS_STROBE_DIS_BIT = 3;
    localparam int SYS_MAP_SEL_BIT = 4;

    localparam logic [7:0] REG_ADDR [NREG] = '{
        8'h80, 8'h86, 8'h87, 8'h88, 8'h88, 8'h89, 8'h8a, 8'h8b, 8'h8c, 8'h8d,
        8'h90, 8'h90, 8'h98, 8'h99, 8'ha0, 8'ha8, 8'ha9, 8'haa, 8'hb0, 8'hb1,
        8'hb8, 8'hba, 8'hc1, 8'hc2, 8'hc3, 8'hc4, 8'hc5, 8'hc6, 8'hc7, 8'hc8,
        8'hca, 8'hcb, 8'hcc, 8'hcd, 8'hd8, 8'he8, 8'hfc, 8'hfd, 8'hfe, 8'h92};
    localparam logic [NREG-1:0] REG_MAPPED = 40'h70_0000_0810;
    localparam logic [7:0] REG_RESET [NREG] = '{
        8'hff, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
        8'hff, 8'hff, 8'h00, 8'h00, 8'hff, 8'h00, 8'h00, 8'hd9, 8'hff, 8'h21,
        8'h00, 8'h03, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h03, VERSION_A, VERSION_B, VERSION_C, 8'h00};
    localparam logic [7:0] REG_WMASK [NREG] = '{
        8'hff, 8'hff, 8'hff, 8'hff, 8'h90, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff,
        8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'h3f,
        8'hff, 8'h03, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hdf,
        8'hff, 8'hff, 8'hff, 8'hff, 8'hdf, 8'h03, 8'h00, 8'h00, 8'h00, 8'h07};

endpackage : sfr_pkg

// ===== logic/sfr_map_ctrl.sv
// Register map decode, system control bits, data pointer bank and data window select.
// Assumes the core issues at most one register request per clock and that reset is
// already synchronised to clock_in outside this block.
//
// Notes on behaviour
// - Eight 16-bit data pointers; pointer select register picks the active one.
// - Map-select clear decodes standard area; set decodes shared addresses to mapped area.
// - Map-select keeps its value; only software or reset changes it.
// - Only analog select, power control ext and three version registers are mapped.
// - Addresses with low three bits zero also allow single-bit read, set, clear.
// - Data space accesses from F700 to F7FF select the CAN controller.
// - CAN switch-off bit zero enables CAN, one switches it off; resets zero.
// - Port 1 analog select shares 90h with port 1 latch; both reset to ones.
// - Power control ext shares 88h, reached with map-select set, bit 7 resets clear.
// - With external access select high, latch strobe disable bit suppresses the strobe.
// - Standard and mapped areas together form the peripheral register interface.
`timescale 1ns/1ps
module sfr_map_ctrl (
    input wire logic clock_in,
    input wire logic nrst_in,
    input wire sfr_pkg::sfr_req_s sfr_req_in,
    output sfr_pkg::sfr_rsp_s sfr_rsp_out,
    input wire sfr_pkg::sfr_xreq_s xreq_in,
    output logic can_sel_out,
    output logic xram_sel_out,
    output logic [7:0] can_offset_out,
    output logic can_enable_out,
    input wire logic external_access_select_in,
    input wire logic ale_req_in,
    output logic ale_out,
    output logic [15:0] dptr_out,
    output logic map_select_out,
    output logic [sfr_pkg::NREG-1:0][7:0] sfr_regs_out
);
    import sfr_pkg::*;

    // ==============================
    // Decode helpers
    // ==============================

    // True when some mapped register sits at this address
    function automatic logic is_mapped_addr(input logic [7:0] addr);
        logic found;
        found = 1'b0;
        for (int i = 0; i < NREG; i++)
        begin
            if (REG_MAPPED[i] && (REG_ADDR[i] == addr))
            begin
                found = 1'b1;
            end
        end
        return found;
    endfunction : is_mapped_addr

    // Returns {hit, index} for a byte address under the current area selection
    function automatic logic [6:0] decode_reg(input logic [7:0] addr, input logic map_select_bit);
        logic [6:0] res;
        logic shadow;
        res = 7'h00;
        shadow = map_select_bit && is_mapped_addr(addr);
        for (int i = 0; i < NREG; i++)
        begin
            if (REG_ADDR[i] == addr)
            begin
                if (REG_MAPPED[i] ? map_select_bit : !shadow)
                begin
                    res = {1'b1, 6'(i)};
                end
            end
        end
        return res;
    endfunction : decode_reg

    // ==============================
    // Request decode
    // ==============================
    logic [7:0] regs_ff [NREG];
    logic [7:0] nxt_regs [NREG];
    logic map_select_bit;
    logic is_bit_op;
    logic is_wr_op;
    logic is_rd_op;
    logic [7:0] byte_addr;
    logic [2:0] bit_pos;
    logic bit_area;
    logic [6:0] dec;
    logic reg_hit;
    logic [5:0] reg_idx;
    logic ptr_lo_hit;
    logic ptr_hi_hit;
    logic [7:0] cur_byte;
    logic [7:0] wr_value;
    logic [15:0] ptr_rd_data;
    logic [1:0] ptr_be;
    logic [2:0] ptr_sel;
    logic any_hit;

    assign map_select_bit = regs_ff[IDX_SYS_CTRL][SYS_MAP_SEL_BIT];
    assign ptr_sel = regs_ff[IDX_PTR_SEL][2:0];

    assign is_bit_op = (sfr_req_in.op == SFR_OP_BIT_RD) || (sfr_req_in.op == SFR_OP_BIT_SET) ||
                       (sfr_req_in.op == SFR_OP_BIT_CLR);
    assign is_wr_op = (sfr_req_in.op == SFR_OP_WR) || (sfr_req_in.op == SFR_OP_BIT_SET) ||
                      (sfr_req_in.op == SFR_OP_BIT_CLR);
    assign is_rd_op = (sfr_req_in.op == SFR_OP_RD) || (sfr_req_in.op == SFR_OP_BIT_RD);

    // Bit addresses below the register area belong to internal RAM, not here
    assign bit_area = sfr_req_in.addr >= BIT_AREA_BASE;
    assign byte_addr = is_bit_op ? {sfr_req_in.addr[7:3], 3'b000} : sfr_req_in.addr;
    assign bit_pos = sfr_req_in.addr[2:0];

    assign dec = decode_reg(byte_addr, map_select_bit);
    assign reg_hit = dec[6] && (!is_bit_op || bit_area);
    assign reg_idx = dec[5:0];

    // Pointer bytes are byte-only locations in the standard area
    assign ptr_lo_hit = !is_bit_op && (sfr_req_in.addr == ADDR_DPL);
    assign ptr_hi_hit = !is_bit_op && (sfr_req_in.addr == ADDR_DPH);
    assign any_hit = reg_hit || ptr_lo_hit || ptr_hi_hit;

    assign cur_byte = reg_hit ? regs_ff[reg_idx] : UNMAPPED_RDATA;

    // ==============================
    // Write value, byte or single bit
    // ==============================
    always_comb
    begin
        wr_value = cur_byte;
        case (sfr_req_in.op)
            SFR_OP_WR:
            begin
                wr_value = sfr_req_in.wdata;
            end
            SFR_OP_BIT_SET:
            begin
                wr_value[bit_pos] = 1'b1;
            end
            SFR_OP_BIT_CLR:
            begin
                wr_value[bit_pos] = 1'b0;
            end
            default:
            begin
                wr_value = cur_byte;
            end
        endcase
    end

    // ==============================
    // Register file next state
    // ==============================
    always_comb
    begin
        for (int i = 0; i < NREG; i++)
        begin
            nxt_regs[i] = regs_ff[i];
        end
        if (is_wr_op && reg_hit)
        begin
            // Masked bits keep their value, so reserved bits stay stable
            nxt_regs[reg_idx] = (regs_ff[reg_idx] & ~REG_WMASK[reg_idx]) |
                                (wr_value & REG_WMASK[reg_idx]);
        end
    end

    // Map-select only moves on a software write; no hardware clear path exists
    always_ff @(posedge clock_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            for (int i = 0; i < NREG; i++)
            begin
                regs_ff[i] <= REG_RESET[i];
            end
        end
        else
        begin
            for (int i = 0; i < NREG; i++)
            begin
                regs_ff[i] <= nxt_regs[i];
            end
        end
    end

    always_comb
    begin
        for (int i = 0; i < NREG; i++)
        begin
            sfr_regs_out[i] = regs_ff[i];
        end
    end

    // ==============================
    // Data pointer bank
    // ==============================
    assign ptr_be = {ptr_hi_hit && (sfr_req_in.op == SFR_OP_WR),
                     ptr_lo_hit && (sfr_req_in.op == SFR_OP_WR)};

    // Only the selected pointer is written or shown; the others hold their values
    sfr_ptr_mem u_ptr_mem (
        .clock_in(clock_in),
        .nrst_in(nrst_in),
        .wr_sel_in(ptr_sel),
        .wr_be_in(ptr_be),
        .wr_byte_in(sfr_req_in.wdata),
        .rd_sel_in(ptr_sel),
        .rd_data_out(ptr_rd_data)
    );

    assign dptr_out = ptr_rd_data;

    // ==============================
    // Register answer
    // ==============================
    always_ff @(posedge clock_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            sfr_rsp_out <= '0;
        end
        else
        begin
            sfr_rsp_out.ack <= sfr_req_in.op != SFR_OP_IDLE;
            sfr_rsp_out.hit <= (sfr_req_in.op != SFR_OP_IDLE) && any_hit;
            if (is_rd_op)
            begin
                if (ptr_lo_hit)
                begin
                    sfr_rsp_out.rdata <= ptr_rd_data[7:0];
                end
                else if (ptr_hi_hit)
                begin
                    sfr_rsp_out.rdata <= ptr_rd_data[15:8];
                end
                else
                begin
                    sfr_rsp_out.rdata <= cur_byte;
                end
                sfr_rsp_out.bit_rdata <= is_bit_op && reg_hit && cur_byte[bit_pos];
            end
        end
    end

    // ==============================
    // External data window
    // ==============================
    // A switched-off controller gives the page back to plain external data space
    always_ff @(posedge clock_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            can_sel_out <= 1'b0;
            xram_sel_out <= 1'b0;
            can_offset_out <= 8'h00;
        end
        else
        begin
            can_sel_out <= xreq_in.valid && (xreq_in.addr[15:8] == CAN_PAGE) &&
                           !regs_ff[IDX_SYS_CTRL][SYS_CAN_OFF_BIT];
            xram_sel_out <= xreq_in.valid && ((xreq_in.addr[15:8] != CAN_PAGE) ||
                            regs_ff[IDX_SYS_CTRL][SYS_CAN_OFF_BIT]);
            can_offset_out <= xreq_in.addr[7:0];
        end
    end

    assign can_enable_out = !regs_ff[IDX_SYS_CTRL][SYS_CAN_OFF_BIT];
    assign map_select_out = map_select_bit;

    // ==============================
    // Address latch strobe gating
    // ==============================
    // Kept combinational so the strobe is not delayed against the bus cycle
    assign ale_out = ale_req_in &&
                     !(external_access_select_in && regs_ff[IDX_SYS_CTRL][SYS_STROBE_DIS_BIT]);

endmodule : sfr_map_ctrl

// ===== logic/sfr_ptr_mem.sv
// Storage for the eight data pointers, byte writable, registered read port.
// Assumes one write and one read per cycle in the core clock domain.
`timescale 1ns/1ps
module sfr_ptr_mem (
    input wire logic clock_in,
    input wire logic nrst_in,
    input wire logic [2:0] wr_sel_in,
    input wire logic [1:0] wr_be_in,
    input wire logic [7:0] wr_byte_in,
    input wire logic [2:0] rd_sel_in,
    output logic [15:0] rd_data_out
);
    import sfr_pkg::*;

    logic [15:0] ptr_ff [NPTR];

    // ==============================
    // Write port
    // ==============================
    always_ff @(posedge clock_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            for (int i = 0; i < NPTR; i++)
            begin
                ptr_ff[i] <= 16'h0000;
            end
        end
        else
        begin
            if (wr_be_in[0])
            begin
                ptr_ff[wr_sel_in][7:0] <= wr_byte_in;
            end
            if (wr_be_in[1])
            begin
                ptr_ff[wr_sel_in][15:8] <= wr_byte_in;
            end
        end
    end

    // ==============================
    // Registered read port
    // ==============================
    always_ff @(posedge clock_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            rd_data_out <= 16'h0000;
        end
        else
        begin
            rd_data_out <= ptr_ff[rd_sel_in];
        end
    end

endmodule : sfr_ptr_mem

// ===== testbench/sfr_map_ctrl_asserts.sv
// Port-level assertions for the register map block.
// Assumes one core clock and an active low asynchronous reset.
`timescale 1ns/1ps
module sfr_map_ctrl_asserts (
    input wire logic clock_in,
    input wire logic nrst_in,
    input wire sfr_pkg::sfr_req_s sfr_req_in,
    input wire sfr_pkg::sfr_rsp_s sfr_rsp_out,
    input wire sfr_pkg::sfr_xreq_s xreq_in,
    input wire logic can_sel_out,
    input wire logic xram_sel_out,
    input wire logic [7:0] can_offset_out,
    input wire logic can_enable_out,
    input wire logic external_access_select_in,
    input wire logic ale_req_in,
    input wire logic ale_out,
    input wire logic [15:0] dptr_out,
    input wire logic map_select_out,
    input wire logic [sfr_pkg::NREG-1:0][7:0] sfr_regs_out
);
    import sfr_pkg::*;
    // ==============================
    // Helpers
    // ==============================
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!nrst_in);
    logic [7:0] sys;
    logic is_bit;
    assign sys = sfr_regs_out[IDX_SYS_CTRL];
    assign is_bit = sfr_req_in.op inside {SFR_OP_BIT_RD, SFR_OP_BIT_SET, SFR_OP_BIT_CLR};
    // ==============================
    // Properties
    // ==============================
    ack_pulse_a: assert property (sfr_rsp_out.ack == ($past(sfr_req_in.op) != SFR_OP_IDLE))
        else $error("ack does not follow request");
    can_sel_a: assert property (xreq_in.valid && xreq_in.addr[15:8] == CAN_PAGE && !sys[SYS_CAN_OFF_BIT]
        |=> can_sel_out && !xram_sel_out) else $error("CAN window not selected");
    xram_sel_a: assert property (xreq_in.valid && (xreq_in.addr[15:8] != CAN_PAGE || sys[SYS_CAN_OFF_BIT])
        |=> xram_sel_out && !can_sel_out) else $error("data space select wrong");
    no_sel_a: assert property (!xreq_in.valid |=> !can_sel_out && !xram_sel_out)
        else $error("select without access");
    can_en_a: assert property (can_enable_out == !sys[SYS_CAN_OFF_BIT])
        else $error("CAN enable mismatch");
    ale_gate_a: assert property (ale_out == (ale_req_in && !(external_access_select_in && sys[SYS_STROBE_DIS_BIT])))
        else $error("strobe gating wrong");
    map_hold_a: assert property (!(sfr_req_in.op == SFR_OP_WR && sfr_req_in.addr == 8'hb1)
        |=> $stable(map_select_out) && map_select_out == sys[SYS_MAP_SEL_BIT]) else $error("map select moved");
    bit_low_a: assert property (is_bit && !sfr_req_in.addr[7] |=> sfr_rsp_out.ack && !sfr_rsp_out.hit)
        else $error("bit access below bit area hit");
    version_ro_a: assert property ($stable(sfr_regs_out[36]))
        else $error("version register changed");
    latch_shadow_a: assert property (sfr_req_in.op == SFR_OP_WR && sfr_req_in.addr == 8'h90 && map_select_out
        |=> $stable(sfr_regs_out[10])) else $error("port latch written while mapped");
    can_offset_a: assert property (1'b1 |=> can_offset_out == $past(xreq_in.addr[7:0]))
        else $error("offset wrong");
    cover property (sfr_rsp_out.ack && sfr_rsp_out.hit && map_select_out);
    cover property (can_sel_out);
    cover property (sfr_rsp_out.ack && !sfr_rsp_out.hit);
endmodule : sfr_map_ctrl_asserts

bind sfr_map_ctrl sfr_map_ctrl_asserts u_asserts (.clock_in(clock_in), .nrst_in(nrst_in),
    .sfr_req_in(sfr_req_in), .sfr_rsp_out(sfr_rsp_out), .xreq_in(xreq_in), .can_sel_out(can_sel_out),
    .xram_sel_out(xram_sel_out), .can_offset_out(can_offset_out), .can_enable_out(can_enable_out),
    .external_access_select_in(external_access_select_in), .ale_req_in(ale_req_in), .ale_out(ale_out),
    .dptr_out(dptr_out), .map_select_out(map_select_out), .sfr_regs_out(sfr_regs_out));

// ===== testbench/sfr_map_ctrl_tb.sv
// Self-checking bench for the register map block.
// Assumes the package constants and a one-cycle register answer.
`timescale 1ns/1ps
module sfr_map_ctrl_tb;
    import sfr_pkg::*;
    logic clock_in = 1'b0;
    logic nrst_in = 1'b0;
    sfr_req_s req = '0;
    sfr_rsp_s rsp;
    sfr_xreq_s xreq = '0;
    logic can_sel, xram_sel, can_en, ale, map_sel;
    logic ext_fetch = 1'b0;
    logic ale_req = 1'b0;
    logic [7:0] offset;
    logic [15:0] dptr;
    logic [NREG-1:0][7:0] regs;
    int error_cnt = 0;
    int num_checks = 0;
    sfr_map_ctrl uut (.clock_in(clock_in), .nrst_in(nrst_in), .sfr_req_in(req), .sfr_rsp_out(rsp),
        .xreq_in(xreq), .can_sel_out(can_sel), .xram_sel_out(xram_sel), .can_offset_out(offset),
        .can_enable_out(can_en), .external_access_select_in(ext_fetch), .ale_req_in(ale_req), .ale_out(ale),
        .dptr_out(dptr), .map_select_out(map_sel), .sfr_regs_out(regs));
    initial
    begin
        forever #4 clock_in = ~clock_in;
    end
    // ==============================
    // Shared tasks
    // ==============================
    task automatic summarize();
        if (error_cnt == 0 && num_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : summarize
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // Answer is fixed at one cycle, so a missing ack ends the run at once
    task automatic acc(input sfr_op_e op, input logic [7:0] a, input logic [7:0] d);
        @(posedge clock_in);
        req <= '{op, a, d};
        @(posedge clock_in);
        req <= '0;
        #1;
        if (rsp.ack !== 1'b1)
        begin
            error_cnt++;
            $display("unexpected at %0t: no ack", $time);
            summarize();
        end
    endtask : acc
    task automatic rd(input logic [7:0] a, input logic [8:0] e);
        acc(SFR_OP_RD, a, 8'h00);
        chk({7'h00, rsp.hit, rsp.rdata}, {7'h00, e});
    endtask : rd
    task automatic xr(input logic [15:0] a, input logic [1:0] e);
        @(posedge clock_in);
        xreq <= '{1'b1, a};
        @(posedge clock_in);
        xreq <= '0;
        #1;
        chk({6'h00, can_sel, xram_sel, offset}, {6'h00, e, a[7:0]});
    endtask : xr
    task automatic do_reset();
        @(posedge clock_in);
        nrst_in <= 1'b0;
        repeat (5) @(posedge clock_in);
        nrst_in <= 1'b1;
    endtask : do_reset
    // ==============================
    // Scenarios
    // ==============================
    task automatic t_reset();
        #1;
        for (int i = 0; i < NREG; i++)
            chk({8'h00, regs[i]}, {8'h00, REG_RESET[i]});
        chk({regs[0], regs[17]}, 16'hffd9);
        chk({regs[10], regs[11]}, 16'hffff);
        chk({14'h0, can_en, map_sel}, 16'h0002);
        chk({15'h0, regs[4][7]}, 16'h0000);
        rd(8'h90, 9'h1ff);
    endtask : t_reset
    task automatic t_map();
        acc(SFR_OP_WR, 8'h90, 8'h5a);
        rd(8'h90, 9'h15a);
        acc(SFR_OP_WR, 8'hb1, 8'h31);
        chk({15'h0, map_sel}, 16'h0001);
        rd(8'h90, 9'h1ff);
        acc(SFR_OP_WR, 8'h90, 8'h0f);
        rd(8'h90, 9'h10f);
        acc(SFR_OP_WR, 8'h88, 8'hff);
        rd(8'h88, 9'h190);
        acc(SFR_OP_WR, 8'hfc, 8'h00);
        rd(8'hfc, {1'b1, VERSION_A});
        rd(8'hfd, {1'b1, VERSION_B});
        rd(8'hfe, {1'b1, VERSION_C});
        rd(8'hb1, 9'h131);
        rd(8'h86, 9'h100);
        acc(SFR_OP_WR, 8'hb1, 8'h21);
        chk({15'h0, map_sel}, 16'h0000);
        rd(8'h90, 9'h15a);
        rd(8'h88, 9'h100);
        rd(8'hfc, 9'h000);
        rd(8'h81, 9'h000);
    endtask : t_map
    task automatic t_bits();
        acc(SFR_OP_BIT_CLR, 8'h83, 8'h00);
        rd(8'h80, 9'h1f7);
        acc(SFR_OP_BIT_RD, 8'h83, 8'h00);
        chk({14'h0, rsp.hit, rsp.bit_rdata}, 16'h0002);
        acc(SFR_OP_BIT_SET, 8'h83, 8'h00);
        acc(SFR_OP_BIT_RD, 8'h87, 8'h00);
        chk({14'h0, rsp.hit, rsp.bit_rdata}, 16'h0003);
        acc(SFR_OP_BIT_SET, 8'h89, 8'h00);
        rd(8'h88, 9'h102);
        rd(8'h89, 9'h100);
        acc(SFR_OP_BIT_SET, 8'h40, 8'h00);
        chk({15'h0, rsp.hit}, 16'h0000);
    endtask : t_bits
    task automatic t_dptr();
        for (int i = 0; i < NPTR; i++)
        begin
            acc(SFR_OP_WR, 8'h92, i[7:0]);
            acc(SFR_OP_WR, 8'h82, 8'h10 | i[7:0]);
            acc(SFR_OP_WR, 8'h83, 8'ha0 | i[7:0]);
        end
        for (int i = NPTR - 1; i >= 0; i--)
        begin
            acc(SFR_OP_WR, 8'h92, i[7:0]);
            repeat (2) @(posedge clock_in);
            #1;
            chk(dptr, {8'ha0 | i[7:0], 8'h10 | i[7:0]});
            rd(8'h83, {1'b1, 8'ha0 | i[7:0]});
        end
    endtask : t_dptr
    task automatic t_xram();
        xr(16'hf712, 2'b10);
        xr(16'hf700, 2'b10);
        xr(16'hf7ff, 2'b10);
        xr(16'hf6ff, 2'b01);
        xr(16'hf800, 2'b01);
        acc(SFR_OP_WR, 8'hb1, 8'h25);
        chk({15'h0, can_en}, 16'h0000);
        xr(16'hf712, 2'b01);
        acc(SFR_OP_WR, 8'hb1, 8'h21);
        chk({15'h0, can_en}, 16'h0001);
    endtask : t_xram
    task automatic t_ale();
        for (int k = 0; k < 8; k++)
        begin
            if (k % 4 == 0)
                acc(SFR_OP_WR, 8'hb1, k[2] ? 8'h29 : 8'h21);
            @(posedge clock_in);
            ext_fetch <= k[0];
            ale_req <= k[1];
            @(posedge clock_in);
            #1;
            chk({15'h0, ale}, {15'h0, k[1] & ~(k[0] & k[2])});
        end
    endtask : t_ale
    // ==============================
    // Main sequence
    // ==============================
    initial
    begin
        do_reset();
        t_reset();
        t_map();
        t_bits();
        t_dptr();
        t_xram();
        t_ale();
        do_reset();
        t_reset();
        summarize();
    end
endmodule : sfr_map_ctrl_tb
